// file: rtl/capsense_mux_defines.vh
`ifndef CAPSENSE_MUX_DEFINES_VH
`define CAPSENSE_MUX_DEFINES_VH

// ============================================================
// Register location
`define SEL_SFR_PAGE        4'h0
`define SEL_SFR_ADDR        8'hAB
`define SEL_RESET           8'h00
`define SEL_CODE_RESET      4'h0

// ============================================================
// Field layout
`define SEL_FIELD_MSB       3
`define SEL_FIELD_W         4
`define SEL_RSVD_W          4

// ============================================================
// Channel decode
`define CH_COUNT            14
`define CODE_P1_BASE        4'h8
`define CODE_P1_4           4'hC
`define CODE_RSVD_LO        4'hE

`endif

// file: rtl/capsense_channel_decode.v
`timescale 1ns/1ps
`include "capsense_mux_defines.vh"
// ============================================================
// One-hot channel decode
module capsense_channel_decode #(
    parameter CH_N = `CH_COUNT
) (
    // Select
    input  wire [3:0]      code_i,
    input  wire            large_pkg_i,
    // Decoded
    output wire [CH_N-1:0] onehot_o,
    output wire            valid_o
);
    genvar g;
    generate
        for (g = 0; g < CH_N; g = g + 1) begin : g_ch
            // Pin 4 of port 1 only exists on the larger package
            if (g == `CODE_P1_4) begin : g_opt
                assign onehot_o[g] = (code_i == g) && large_pkg_i;
            end else begin : g_std
                assign onehot_o[g] = (code_i == g);
            end
        end
    endgenerate

    // Codes at or above the reserved base select nothing
    assign valid_o = |onehot_o;
endmodule

// file: rtl/capsense_channel_select.v
`timescale 1ns/1ps
`include "capsense_mux_defines.vh"
module capsense_channel_select #(
    parameter CH_N = `CH_COUNT
) (
    // Clock and reset
    input  wire            clk_i,
    input  wire            rst_i,
    // Special-function-register bus
    input  wire [3:0]      sfr_page_i,
    input  wire [7:0]      sfr_addr_i,
    input  wire            sfr_wr_i,
    input  wire [7:0]      sfr_wdata_i,
    output wire [7:0]      sfr_rdata_o,
    output wire            sfr_hit_o,
    // Auto-scan update from the converter
    input  wire            scan_load_i,
    input  wire [3:0]      scan_code_i,
    // Package option
    input  wire            large_pkg_i,
    // Multiplexer controls
    output wire [CH_N-1:0] ch_sel_o,
    output wire            ch_valid_o,
    output wire [3:0]      sel_code_o
);
    // ============================================================
    // Local sizes and codes
    localparam FIELD_W = `SEL_FIELD_W;
    localparam RSVD_W  = `SEL_RSVD_W;
    localparam DATA_W  = FIELD_W + RSVD_W;

    localparam [FIELD_W-1:0] RESET_CODE = `SEL_CODE_RESET;
    localparam [3:0]         PAGE_CODE  = `SEL_SFR_PAGE;
    localparam [7:0]         ADDR_CODE  = `SEL_SFR_ADDR;

    // Load source, one-hot
    localparam [2:0] SRC_NONE = 3'b001;
    localparam [2:0] SRC_FW   = 3'b010;
    localparam [2:0] SRC_SCAN = 3'b100;

    // ============================================================
    // Register address decode
    wire page_match;
    wire addr_match;
    wire hit;

    assign page_match = (sfr_page_i == PAGE_CODE);
    assign addr_match = (sfr_addr_i == ADDR_CODE);
    assign hit        = page_match && addr_match;

    // ============================================================
    // Write data field
    wire [FIELD_W-1:0] wdata_field;

    // Upper bits of the write byte are dropped here, so they can never land
    genvar b;
    generate
        for (b = 0; b < FIELD_W; b = b + 1) begin : g_wfield
            assign wdata_field[b] = sfr_wdata_i[b];
        end
    endgenerate

    // ============================================================
    // Load qualification
    wire fw_load;
    wire scan_load;

    assign fw_load   = sfr_wr_i && hit;
    assign scan_load = scan_load_i;

    // ============================================================
    // Load source selection
    reg [2:0] load_src;

    // Firmware write wins if both arrive in one cycle: it is the explicit request
    always @* begin
        load_src = SRC_NONE;
        if (fw_load) begin
            load_src = SRC_FW;
        end else if (scan_load) begin
            load_src = SRC_SCAN;
        end
    end

    // ============================================================
    // Next select value
    reg  [FIELD_W-1:0] sel_r;
    reg  [FIELD_W-1:0] sel_nxt;

    always @* begin
        sel_nxt = sel_r;
        case (load_src)
            SRC_FW: begin
                sel_nxt = wdata_field;
            end
            SRC_SCAN: begin
                sel_nxt = scan_code_i;
            end
            SRC_NONE: begin
                sel_nxt = sel_r;
            end
            default: begin
                sel_nxt = sel_r;
            end
        endcase
    end

    // ============================================================
    // Select register
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_r <= RESET_CODE;
        end else begin
            sel_r <= sel_nxt;
        end
    end

    // ============================================================
    // Read path
    wire [DATA_W-1:0] rdata_word;

    // Reserved bits are tied low per bit rather than stored: no flop to leak a write
    generate
        for (b = 0; b < DATA_W; b = b + 1) begin : g_rbit
            if (b < FIELD_W) begin : g_field
                assign rdata_word[b] = sel_r[b];
            end else begin : g_rsvd
                assign rdata_word[b] = 1'b0;
            end
        end
    endgenerate

    assign sfr_hit_o   = hit;
    assign sfr_rdata_o = hit ? rdata_word : {DATA_W{1'b0}};
    assign sel_code_o  = sel_r;

    // ============================================================
    // Decode
    // The decode reads the stored code, so a reserved value stays stored
    // but routes no pin until firmware or the scan logic replaces it
    capsense_channel_decode #(
        .CH_N (CH_N)
    ) u_decode (
        .code_i      (sel_r),
        .large_pkg_i (large_pkg_i),
        .onehot_o    (ch_sel_o),
        .valid_o     (ch_valid_o)
    );
endmodule

// file: tb/capsense_sel_assertions.sv
`timescale 1ns/1ps
// ====
// Select checks
module capsense_sel_chk #(parameter CH_N = 14) (
    input wire clk_i, rst_i, sfr_wr_i, sfr_hit_o, scan_load_i, large_pkg_i, ch_valid_o,
    input wire [7:0] sfr_wdata_i, sfr_rdata_o,
    input wire [3:0] scan_code_i, sel_code_o,
    input wire [CH_N-1:0] ch_sel_o);
    wire fw = sfr_wr_i && sfr_hit_o;
    wire [3:0] wd = sfr_wdata_i[3:0];
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_fw_load: assert property (fw |=> sel_code_o == $past(wd)) else $error("write lost");
    a_scan_load: assert property (scan_load_i && !fw |=> sel_code_o == $past(scan_code_i)) else $error("scan lost");
    a_rsvd_bits: assert property (sfr_rdata_o[7:4] == 4'h0) else $error("upper bits");
    a_one_hot: assert property (ch_valid_o |-> ch_sel_o == 1 << sel_code_o) else $error("bad pin");
    a_rsvd_code: assert property (sel_code_o > 4'hD |-> !ch_sel_o && !ch_valid_o) else $error("bad code");
    a_pkg_only: assert property (sel_code_o == 4'hC |-> ch_valid_o == large_pkg_i) else $error("package");
    cover property (fw);
    cover property (scan_load_i);
    cover property (!ch_valid_o);
    cover property (fw && scan_load_i);
endmodule
bind capsense_channel_select capsense_sel_chk #(.CH_N(CH_N)) i_chk (.*);

// file: tb/capsense_scan_model.sv
`timescale 1ns/1ps
// Released code lines show the inverse, not the old code
module capsense_scan_model (input wire clk_i, output reg load_o = 1'b0, output reg [3:0] code_o = 4'h0);
    task load(input [3:0] c); begin
        @(negedge clk_i) {load_o, code_o} = {1'b1, c};
        @(negedge clk_i) {load_o, code_o} = {1'b0, ~c};
    end endtask
endmodule

// file: tb/capsense_channel_select_tb_top.sv
`timescale 1ns/1ps
module capsense_channel_select_tb_top;
    reg clk_i = 0, rst_i = 1, sfr_wr_i = 0, large_pkg_i = 1;
    reg [3:0] sfr_page_i = 4'h0;
    reg [7:0] sfr_addr_i = 8'hAB, sfr_wdata_i = 8'h00;
    wire [7:0] sfr_rdata_o;
    wire [3:0] scan_code_i, sel_code_o;
    wire [13:0] ch_sel_o;
    wire sfr_hit_o, scan_load_i, ch_valid_o;
    integer failures = 0, checks_done = 0, i;
    initial forever #12.5 clk_i = ~clk_i;
    capsense_channel_select i_capsense_channel_select (.*);
    capsense_scan_model i_capsense_scan_model (.clk_i(clk_i), .load_o(scan_load_i), .code_o(scan_code_i));
    task chk(input [15:0] s, e); begin
        checks_done++;
        if (s !== e) begin failures++; $display("unexpected %0t %h %h", $time, s, e); end
    end endtask
    task wr(input [7:0] a, d); begin
        @(negedge clk_i) {sfr_addr_i, sfr_wdata_i, sfr_wr_i} = {a, d, 1'b1};
        @(negedge clk_i) {sfr_addr_i, sfr_wr_i} = {8'hAB, 1'b0};
    end endtask
    task conclude; begin
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    end endtask
    initial begin
        repeat (8) @(negedge clk_i);
        rst_i = 0;
        chk(ch_sel_o, 16'h0001);
        for (i = 0; i < 16; i++) begin
            wr(8'hAB, 8'hF0 | i);
            chk(sfr_rdata_o, i);
            chk(ch_sel_o, i < 14 ? 1 << i : 0);
        end
        $display("test codes done");
        large_pkg_i = 0;
        wr(8'hAB, 8'h0C);
        chk(ch_valid_o, 16'h0000);
        chk(ch_sel_o, 16'h0000);
        $display("test package done");
        sfr_page_i = 4'h1;
        wr(8'hAB, 8'h05);
        sfr_page_i = 4'h0;
        wr(8'hAA, 8'h05);
        chk(sel_code_o, 16'h000C);
        sfr_addr_i = 8'hAA;
        #1;
        chk(sfr_hit_o, 16'h0000);
        chk(sfr_rdata_o, 16'h0000);
        sfr_addr_i = 8'hAB;
        #1;
        chk(sfr_hit_o, 16'h0001);
        $display("test address done");
        i_capsense_scan_model.load(4'h3);
        chk(ch_sel_o, 16'h0008);
        fork
            wr(8'hAB, 8'h07);
            i_capsense_scan_model.load(4'h2);
        join
        chk(sel_code_o, 16'h0007);
        $display("test scan done");
        rst_i = 1;
        #1;
        chk(sel_code_o, 16'h0000);
        chk(ch_sel_o, 16'h0001);
        @(negedge clk_i) rst_i = 0;
        wr(8'hAB, 8'h09);
        chk(sel_code_o, 16'h0009);
        $display("test reset done");
        conclude;
    end
endmodule
